// *** inc/thermal_pkg.sv ***
// Constants shared by the thermal status logic and its per-channel offset unit.
// Assumes a 125 MHz ref_clk and a mode-register access port decoded upstream.
package thermal_pkg;
  localparam int unsigned CLK_MHZ = 125;
  // Sensor update interval, in ms, longest
  localparam int unsigned SENSOR_UPDATE_INTERVAL_MS = 32;
  localparam int unsigned SENSOR_UPDATE_CYCLES = SENSOR_UPDATE_INTERVAL_MS * 1000 * CLK_MHZ;
  // Offset effect deadline, in us, longest
  localparam int unsigned OFFSET_EFFECT_US = 200;
  localparam int unsigned OFFSET_EFFECT_CYCLES = OFFSET_EFFECT_US * CLK_MHZ;
  // Temperature margin kept ahead of the controller, degrees C
  localparam int unsigned TEMP_MARGIN_C = 2;
  // Thermal mode register address and field layout
  localparam logic [5:0] THERMAL_MODE_REG_ADDR = 6'h04;
  localparam int unsigned STATUS_LSB = 0;
  localparam int unsigned STATUS_MSB = 2;
  localparam int unsigned OFFSET_LSB = 5;
  localparam int unsigned OFFSET_MSB = 6;
  localparam logic [2:0] STATUS_RESET = 3'h3;
  localparam logic [1:0] OFFSET_RESET = 2'h0;
  localparam logic [2:0] STATUS_MAX = 3'h7;
  localparam int unsigned NUM_CHANNELS = 2;
endpackage

// *** hw/channel_offset.sv ***
// One channel's thermal offset store and offset-adjusted status code.
// Assumes the raw status code is already synchronised to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module channel_offset
  import thermal_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Offset write
  input wire logic wr_en,
  input wire logic [1:0] wr_offset,
  // Status
  input wire logic [2:0] raw_status,
  output logic [1:0] offset,
  output logic [2:0] adj_status
);
  logic [1:0] offset_reg, offset_next;
  logic [2:0] adj_reg, adj_next;
  logic [3:0] sum;

  always_comb begin
    offset_next = offset_reg;
    if (wr_en) begin
      offset_next = wr_offset; // see RULE8
    end
    // Offset raises the code seen by self refresh, saturating at the top code
    sum = {1'b0, raw_status} + {2'h0, offset_reg};
    adj_next = sum[3] ? STATUS_MAX : sum[2:0]; // see RULE8
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      offset_reg <= OFFSET_RESET;
      adj_reg <= STATUS_RESET;
    end else begin
      offset_reg <= offset_next;
      adj_reg <= adj_next;
    end
  end

  assign offset = offset_reg;
  assign adj_status = adj_reg;

  offset_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE8
    !wr_en |=> offset_reg == $past(offset_reg)) else $error("offset changed without write");
endmodule
`default_nettype wire

// *** hw/dram_temp_sensor_reporting.sv ***
// Temperature status and thermal offset logic of the thermal mode register.
// Assumes sensor code arrives asynchronously and mode-register commands are
// already decoded on ref_clk with a per-channel select.
//
// Behaviour
// RULE1: Refresh status at most every 32 ms.
// RULE2: Status fresh when clock enable rises.
// RULE3: Keep updating in self refresh, enable high.
// RULE4: Status in bits 2..0; 011 hot.
// RULE5: Keep 2 C margin before controller deadline.
// RULE6: Controller sizes polling period for 2 C.
// RULE7: Controller writes offset to bits 6..5.
// RULE8: Offset applies only to written channel.
// RULE9: Offset visible in status within 200 us.
// RULE10: Controller avoids self refresh above 15 C.
// RULE11: Read returns latest status plus offset.
`timescale 1ns/1ps
`default_nettype none
module dram_temp_sensor_reporting
  import thermal_pkg::*;
#(
  parameter int unsigned UPDATE_CYCLES = SENSOR_UPDATE_CYCLES,
  parameter int unsigned EFFECT_CYCLES = OFFSET_EFFECT_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Memory state
  input wire logic cke,
  input wire logic self_refresh,
  // Sensor, asynchronous; already includes the margin shift
  input wire logic [2:0] sensor_code,
  // Mode register access
  input wire logic mr_wr,
  input wire logic mr_rd,
  input wire logic [5:0] mr_addr,
  input wire logic [7:0] mr_wdata,
  input wire logic [1:0] ch_sel,
  output logic [7:0] mr_rdata,
  output logic mr_rvalid,
  // Self refresh rate code per channel
  output logic [2:0] temp_comp_self_refresh_code0,
  output logic [2:0] temp_comp_self_refresh_code1
);
  localparam int unsigned CW = 32;

  function automatic logic hit(input logic [5:0] a);
    hit = (a == THERMAL_MODE_REG_ADDR);
  endfunction

  ////////////////////////////////////////////////////////////////
  // Sensor synchroniser: three stages, change taken when 2 and 3 agree
  logic [2:0] s1_reg, s2_reg, s3_reg;
  logic [2:0] code_reg, code_next;
  logic [CW-1:0] tick_reg, tick_next;
  logic cke_d_reg;
  logic [2:0] status_reg, status_next;

  always_comb begin
    code_next = (s2_reg == s3_reg) ? s3_reg : code_reg;
    tick_next = tick_reg + 32'h1;
    status_next = status_reg;
    // Sampling restarts on a clock enable rise so the code is never stale;
    // it also runs in self refresh since the sampler ignores power state
    if (cke && !cke_d_reg) begin
      tick_next = 32'h0; // see RULE2
      status_next = code_reg[2:0]; // see RULE2
    end else if (tick_reg >= UPDATE_CYCLES - 1) begin
      tick_next = 32'h0; // see RULE1
      status_next = code_reg[STATUS_MSB:STATUS_LSB]; // see RULE1, RULE3, RULE4, RULE5
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_reg <= STATUS_RESET;
      s2_reg <= STATUS_RESET;
      s3_reg <= STATUS_RESET;
      code_reg <= STATUS_RESET;
      tick_reg <= 32'h0;
      // Idle level of cke is high, so reset must not fake a rise
      cke_d_reg <= 1'b1;
      status_reg <= STATUS_RESET;
    end else begin
      s1_reg <= sensor_code;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      code_reg <= code_next;
      tick_reg <= tick_next;
      cke_d_reg <= cke;
      status_reg <= status_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Per-channel offsets
  logic [1:0] ch_offset [NUM_CHANNELS];
  logic [2:0] ch_adj [NUM_CHANNELS];

  genvar g;
  generate
    for (g = 0; g < NUM_CHANNELS; g++) begin : g_ch
      channel_offset u_ch (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .wr_en(mr_wr && hit(mr_addr) && ch_sel[g]), // see RULE7, RULE8
        .wr_offset(mr_wdata[OFFSET_MSB:OFFSET_LSB]),
        .raw_status(status_reg),
        .offset(ch_offset[g]),
        .adj_status(ch_adj[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Read path and outputs; the adjusted code appears two cycles after a write
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [2:0] tc0_reg, tc1_reg;
  logic rd_ch;

  always_comb begin
    rd_ch = ch_sel[1] && !ch_sel[0];
    rvalid_next = mr_rd;
    rdata_next = rdata_reg;
    if (mr_rd) begin
      rdata_next = 8'h00;
      if (hit(mr_addr)) begin
        rdata_next[STATUS_MSB:STATUS_LSB] = rd_ch ? ch_adj[1] : ch_adj[0]; // see RULE11, RULE9
        rdata_next[OFFSET_MSB:OFFSET_LSB] = rd_ch ? ch_offset[1] : ch_offset[0]; // see RULE11
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      tc0_reg <= STATUS_RESET;
      tc1_reg <= STATUS_RESET;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      tc0_reg <= ch_adj[0]; // see RULE9
      tc1_reg <= ch_adj[1];
    end
  end

  assign mr_rdata = rdata_reg;
  assign mr_rvalid = rvalid_reg;
  assign temp_comp_self_refresh_code0 = tc0_reg;
  assign temp_comp_self_refresh_code1 = tc1_reg;

  ////////////////////////////////////////////////////////////////
  // Offset effect watch: after a write, each written channel's rate code must
  // reach its offset-adjusted status before the effect deadline; a lag
  // counter keeps the bound cheap where a delay range would be huge
  function automatic logic [2:0] sat_add(input logic [2:0] code, input logic [1:0] off);
    logic [3:0] s;
    s = {1'b0, code} + {2'h0, off};
    sat_add = s[3] ? STATUS_MAX : s[2:0];
  endfunction

  generate
    for (g = 0; g < NUM_CHANNELS; g++) begin : g_lag
      logic [CW-1:0] lag_reg, lag_next;
      logic [2:0] rate_now;

      assign rate_now = (g == 0) ? tc0_reg : tc1_reg;

      always_comb begin
        lag_next = lag_reg;
        if (mr_wr && hit(mr_addr) && ch_sel[g]) begin
          lag_next = 32'h1;
        end else if (lag_reg != 32'h0) begin
          lag_next = (rate_now == sat_add(status_reg, ch_offset[g])) ? 32'h0 : lag_reg + 32'h1;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          lag_reg <= 32'h0;
        end else begin
          lag_reg <= lag_next;
        end
      end

      effect_due_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE9
        lag_reg < EFFECT_CYCLES) else $error("offset effect overdue");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Checks
  tick_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE1
    tick_reg < UPDATE_CYCLES) else $error("update interval overrun");
  cke_fresh_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE2
    cke && !cke_d_reg |=> tick_reg == 0 && status_reg == $past(code_reg)) else $error("stale at cke rise");
  sref_update_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE3
    self_refresh && tick_reg == UPDATE_CYCLES - 1 && !(cke && !cke_d_reg) |=> status_reg == $past(code_reg))
    else $error("no update in self refresh");
  status_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE1
    tick_reg != UPDATE_CYCLES - 1 && !(cke && !cke_d_reg) |=> $stable(status_reg)) else $error("status moved early");
  rd_valid_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE11
    mr_rd |=> mr_rvalid) else $error("read not answered");
  rd_reserved_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE11
    mr_rd |=> mr_rdata[4:3] == 2'h0 && mr_rdata[7] == 1'b0) else $error("reserved bits set");
  rd_offset_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE11
    mr_rd && hit(mr_addr) && !rd_ch |=> mr_rdata[6:5] == $past(ch_offset[0])) else $error("offset read wrong");
  effect_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE9
    mr_wr && hit(mr_addr) && ch_sel[0] |=> ##[1:3] temp_comp_self_refresh_code0 == ch_adj[0]) else $error("offset effect late");
  other_ch_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE8
    mr_wr && hit(mr_addr) && ch_sel == 2'h1 |=> $stable(ch_offset[1])) else $error("offset leaked");

  cke_rise_c: cover property (@(posedge ref_clk) disable iff (!rst_n) cke && !cke_d_reg);
  periodic_c: cover property (@(posedge ref_clk) disable iff (!rst_n) tick_reg == UPDATE_CYCLES - 1);
  wr_both_c: cover property (@(posedge ref_clk) disable iff (!rst_n) mr_wr && hit(mr_addr) && ch_sel == 2'h3);
  rd_c: cover property (@(posedge ref_clk) disable iff (!rst_n) mr_rd && hit(mr_addr));
  wr_one_c: cover property (@(posedge ref_clk) disable iff (!rst_n) mr_wr && hit(mr_addr) && ch_sel == 2'h1);
endmodule
`default_nettype wire

// *** tb/mr_controller.sv ***
// Memory controller model: issues thermal register reads and writes.
// Assumes ref_clk is the device clock; drives 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module mr_controller (
  // Clock
  input wire logic ref_clk,
  // Mode register access
  output logic mr_wr,
  output logic mr_rd,
  output logic [5:0] mr_addr,
  output logic [7:0] mr_wdata,
  output logic [1:0] ch_sel,
  input wire logic [7:0] mr_rdata,
  input wire logic mr_rvalid
);
  initial begin
    mr_wr = 1'b0;
    mr_rd = 1'b0;
    mr_addr = 6'h3f;
    mr_wdata = 8'hff;
    ch_sel = 2'h0;
  end
  ////////////////////////////////////////////////////////////////
  // Offsets stay small so the hot spot gradient is modest
  task automatic wr(input logic [5:0] a, input logic [1:0] d, input logic [1:0] s);
    @(posedge ref_clk);
    #1;
    mr_addr = a;
    mr_wdata = {1'b0, d, 5'h00};
    ch_sel = s;
    mr_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    mr_wr = 1'b0;
    // Released lines show junk, not the old value
    mr_addr = ~a;
    mr_wdata = ~mr_wdata;
  endtask
  // Polled far more often than the slope budget needs
  task automatic rd(input logic [5:0] a, input logic [1:0] s, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    #1;
    mr_addr = a;
    ch_sel = s;
    mr_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    mr_rd = 1'b0;
    mr_addr = ~a;
    while (mr_rvalid !== 1'b1 && n < 4) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    q = (mr_rvalid === 1'b1) ? mr_rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the thermal status and offset logic.
// Assumes a short update period so periodic sampling is seen quickly.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import thermal_pkg::*;
  localparam int unsigned UPD = 200;
  logic ref_clk;
  logic rst_n;
  logic cke;
  logic self_refresh;
  logic [2:0] sensor_code;
  logic [2:0] temp_comp_self_refresh_code0;
  logic [2:0] temp_comp_self_refresh_code1;
  logic mr_wr;
  logic mr_rd;
  logic mr_rvalid;
  logic [5:0] mr_addr;
  logic [7:0] mr_wdata;
  logic [7:0] mr_rdata;
  logic [7:0] q;
  logic [1:0] ch_sel;
  int bad_count;
  int tests_run;
  dram_temp_sensor_reporting #(.UPDATE_CYCLES(UPD), .EFFECT_CYCLES(OFFSET_EFFECT_CYCLES)) uut (
    .ref_clk, .rst_n, .cke, .self_refresh, .sensor_code, .mr_wr, .mr_rd, .mr_addr,
    .mr_wdata, .ch_sel, .mr_rdata, .mr_rvalid, .temp_comp_self_refresh_code0, .temp_comp_self_refresh_code1);
  mr_controller ctrl (
    .ref_clk, .mr_wr, .mr_rd, .mr_addr, .mr_wdata, .ch_sel, .mr_rdata, .mr_rvalid);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t read data %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_code(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t rate code %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    ctrl.rd(6'h04, 2'b01, q);
    chk_rd(q, 8'h03);
    chk_code(temp_comp_self_refresh_code1, STATUS_RESET);
    ctrl.rd(6'h05, 2'b01, q);
    chk_rd(q, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_periodic();
    self_refresh = 1'b1;
    sensor_code = 3'h5;
    wait_cyc(UPD + 8);
    chk_code(temp_comp_self_refresh_code0, 3'h5);
    ctrl.rd(6'h04, 2'b01, q);
    chk_rd(q, 8'h05);
    $display("test periodic done");
  endtask
  task automatic t_offset();
    ctrl.wr(6'h04, 2'h2, 2'b10);
    wait_cyc(4);
    chk_code(temp_comp_self_refresh_code1, 3'h7);
    chk_code(temp_comp_self_refresh_code0, 3'h5);
    ctrl.rd(6'h04, 2'b10, q);
    chk_rd(q, 8'h47);
    ctrl.wr(6'h04, 2'h1, 2'b11);
    ctrl.wr(6'h05, 2'h3, 2'b11);
    wait_cyc(4);
    chk_code(temp_comp_self_refresh_code0, 3'h6);
    ctrl.rd(6'h04, 2'b10, q);
    chk_rd(q, 8'h26);
    $display("test offset done");
  endtask
  task automatic t_cke();
    cke = 1'b0;
    sensor_code = 3'h1;
    wait_cyc(6);
    chk_code(temp_comp_self_refresh_code0, 3'h6);
    cke = 1'b1;
    wait_cyc(8);
    chk_code(temp_comp_self_refresh_code0, 3'h2);
    $display("test clock enable done");
  endtask
  task automatic t_single();
    ctrl.wr(6'h04, 2'h3, 2'b01);
    wait_cyc(4);
    chk_code(temp_comp_self_refresh_code0, 3'h4);
    chk_code(temp_comp_self_refresh_code1, 3'h2);
    ctrl.rd(6'h04, 2'b01, q);
    chk_rd(q, 8'h64);
    ctrl.rd(6'h04, 2'b10, q);
    chk_rd(q, 8'h22);
    $display("test single channel done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    bad_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    cke = 1'b1;
    self_refresh = 1'b0;
    sensor_code = 3'h3;
    repeat (8) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_periodic();
    t_offset();
    t_cke();
    t_single();
    summarize();
  end
  // Whole run is near 264 cycles; a hang is cut well beyond that
  initial begin
    #(8 * 20000);
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
